// ---- rts_panel_model.sv ----
// behavioural panels and converter facing the touch scanner
`timescale 1ns/1ps
`default_nettype none
module rts_panel_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // scanner side
  input wire logic [11:0] drive,
  input wire logic adc_start,
  output logic adc_done,
  output logic [11:0] adc_data,
  // scenario control: pressed panels, answer delay
  input wire logic [2:0] press,
  input wire logic [3:0] dly
);
  logic [1:0] p;
  logic [3:0] cnt;
  logic busy;
  logic [11:0] smp;
  logic [3:0] nib;
  assign nib = drive[4*p +: 4];
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p <= 2'h0;
      busy <= 1'b0;
      adc_done <= 1'b0;
      adc_data <= 12'h000;
    end else if (adc_start && !busy) begin
      busy <= 1'b1;
      cnt <= dly;
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
      if (nib == 4'h3) begin
        smp <= 12'hA00 + 12'(p);
      end else if (nib == 4'h6) begin
        smp <= 12'h500 + 12'(p);
      end else begin
        // threshold boundary values either side of mid scale
        smp <= press[p] ? 12'h800 : 12'h7FF;
      end
      if (nib == 4'h6 || (nib == 4'hF && !press[p])) begin
        p <= (p == 2'h2) ? 2'h0 : p + 2'h1;
      end
    end else if (busy && cnt == 4'h0) begin
      busy <= 1'b0;
      adc_done <= 1'b1;
      adc_data <= smp;
    end else begin
      cnt <= cnt - 4'h1;
      adc_done <= 1'b0;
      // data is not held outside the answer cycle
      adc_data <= ~adc_data;
    end
  end
endmodule
`default_nettype wire

// ---- rts_params.svh ----
// timing and field constants for the resistive touch scanner
`ifndef RTS_PARAMS_SVH
`define RTS_PARAMS_SVH

// ----------------------------------------------------------------
// counts
// ----------------------------------------------------------------
`define RTS_PANELS 3
`define RTS_CLK_MHZ 50
`define RTS_SETTLE_US 10
`define RTS_SETTLE_CYC (`RTS_SETTLE_US * `RTS_CLK_MHZ)
`define RTS_ADC_BITS 12

// ----------------------------------------------------------------
// drive line positions within a panel's drive word
// ----------------------------------------------------------------
`define RTS_DRV_XA 0
`define RTS_DRV_XR 1
`define RTS_DRV_YA 2
`define RTS_DRV_LO 3

// ----------------------------------------------------------------
// drive patterns: bit set = line at supply
// ----------------------------------------------------------------
`define RTS_PAT_IDLE 4'hF
`define RTS_PAT_X 4'h3
`define RTS_PAT_Y 4'h6

`endif

// ---- rts_pkg.sv ----
// types shared by the resistive touch scanner
`default_nettype none
`include "rts_params.svh"
package rts_pkg;
  typedef struct packed {
    logic [`RTS_ADC_BITS-1:0] x;
    logic [`RTS_ADC_BITS-1:0] y;
  } rts_pos_type;

  typedef enum logic [6:0] {
    RTS_IDLE_SET = 7'h01,
    RTS_IDLE_CONV = 7'h02,
    RTS_X_SET = 7'h04,
    RTS_X_CONV = 7'h08,
    RTS_Y_SET = 7'h10,
    RTS_Y_CONV = 7'h20,
    RTS_NEXT = 7'h40
  } rts_state_type;
endpackage
`default_nettype wire

// ---- rts_scan.sv ----
// touch panel scanner: presence check and x/y read of three panels
// ----------------------------------------------------------------
// Functional notes
// - three five-wire panels visited in fixed rotation
// - idle check drives all four lines high
// - sample nearer ground means no touch
// - sample nearer supply starts position cycle
// - x phase: x and right high, rest low
// - y phase: y and right high, rest low
// - move to next panel, keep cycling
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "rts_params.svh"
module rts_scan #(
  parameter int PANELS = `RTS_PANELS,
  parameter int ADC_BITS = `RTS_ADC_BITS,
  parameter int SETTLE_CYC = `RTS_SETTLE_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // panel drive lines, one group of four per panel
  output logic [4*PANELS-1:0] drive,
  // converter request and answer (same clock)
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [ADC_BITS-1:0] adc_data,
  // results to display logic
  output rts_pkg::rts_pos_type [PANELS-1:0] pos,
  output logic [PANELS-1:0] touched,
  output logic [PANELS-1:0] pos_valid
);
  import rts_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rts_state_type state;
  rts_state_type next_state;
  logic [1:0] panel;
  logic [15:0] settle;
  logic [ADC_BITS-1:0] x_hold;
  logic req_sent;
  logic [1:0] next_panel;
  logic [3:0] next_pattern;
  wire logic [4*PANELS-1:0] next_drive;
  logic settled;
  logic is_conv;
  logic high_half;
  logic last_panel;

  // midpoint compare: msb set means closer to supply
  assign high_half = adc_data[ADC_BITS-1];
  assign settled = (settle == 16'h0000);
  assign last_panel = (panel == 2'(PANELS-1));
  assign is_conv = (state == RTS_IDLE_CONV) || (state == RTS_X_CONV) ||
                   (state == RTS_Y_CONV);
  // one request per conversion state once settled
  assign adc_start = is_conv && settled && !req_sent;

  assign next_panel = (state != RTS_NEXT) ? panel :
                      last_panel ? 2'h0 : panel + 2'h1;

  // levels are worked out one state ahead and registered, so the load
  // switches never see a decode glitch
  assign next_pattern =
    (next_state == RTS_X_SET || next_state == RTS_X_CONV) ? `RTS_PAT_X :
    (next_state == RTS_Y_SET || next_state == RTS_Y_CONV) ? `RTS_PAT_Y :
    `RTS_PAT_IDLE;

  // only the visited panel sees measurement patterns; others rest high
  genvar g;
  generate
    for (g = 0; g < PANELS; g++) begin : g_drv
      assign next_drive[4*g +: 4] = (next_panel == 2'(g)) ? next_pattern :
                                    `RTS_PAT_IDLE;
    end
  endgenerate

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      RTS_IDLE_SET: next_state = RTS_IDLE_CONV;
      RTS_IDLE_CONV: begin
        if (adc_done && req_sent) begin
          next_state = high_half ? RTS_X_SET : RTS_NEXT;
        end
      end
      RTS_X_SET: next_state = RTS_X_CONV;
      RTS_X_CONV: begin
        if (adc_done && req_sent) begin
          next_state = RTS_Y_SET;
        end
      end
      RTS_Y_SET: next_state = RTS_Y_CONV;
      RTS_Y_CONV: begin
        if (adc_done && req_sent) begin
          next_state = RTS_NEXT;
        end
      end
      RTS_NEXT: next_state = RTS_IDLE_SET;
      default: next_state = RTS_IDLE_SET;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= RTS_IDLE_SET;
      panel <= 2'h0;
      drive <= {PANELS{`RTS_PAT_IDLE}};
      settle <= 16'h0000;
      req_sent <= 1'b0;
    end else begin
      state <= next_state;
      drive <= next_drive;
      // settle counter loads in every set state, after that state's drive levels are registered
      if (state == RTS_IDLE_SET || state == RTS_X_SET ||
          state == RTS_Y_SET) begin
        settle <= 16'(SETTLE_CYC);
      end else if (!settled) begin
        settle <= settle - 16'h0001;
      end
      if (adc_start) begin
        req_sent <= 1'b1;
      end else if (!is_conv) begin
        req_sent <= 1'b0;
      end else if (adc_done) begin
        req_sent <= 1'b0;
      end
      panel <= next_panel;
    end
  end

  // ----------------------------------------------------------------
  // results; positions kept until replaced by a fresh pair
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      x_hold <= '0;
      pos <= '0;
      touched <= '0;
      pos_valid <= '0;
    end else begin
      if (state == RTS_IDLE_CONV && adc_done && req_sent) begin
        touched[panel] <= high_half;
      end
      if (state == RTS_X_CONV && adc_done && req_sent) begin
        x_hold <= adc_data;
      end
      if (state == RTS_Y_CONV && adc_done && req_sent) begin
        pos[panel].x <= x_hold;
        pos[panel].y <= adc_data;
        pos_valid[panel] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // cycles since the drive levels last moved, for the settling check
  logic [15:0] drive_age;
  logic [4*PANELS-1:0] drive_seen;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      drive_seen <= {PANELS{`RTS_PAT_IDLE}};
      drive_age <= 16'h0000;
    end else begin
      drive_seen <= drive;
      if (drive != drive_seen) begin
        drive_age <= 16'h0000;
      end else if (drive_age != 16'hFFFF) begin
        drive_age <= drive_age + 16'h0001;
      end
    end
  end

  sequence x_read_s;
    state == RTS_X_CONV && adc_done && req_sent;
  endsequence

  sequence y_read_s;
    state == RTS_Y_CONV && adc_done && req_sent;
  endsequence

  panel_range_a: assert property (
    @(posedge ref_clk) disable iff (rst) panel < 2'(PANELS))
    else $error("panel index out of range");

  idle_drive_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    state == RTS_IDLE_CONV |-> drive == {PANELS{`RTS_PAT_IDLE}})
    else $error("idle check not all high");

  no_touch_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    state == RTS_IDLE_CONV && adc_done && req_sent && !high_half
    |=> state == RTS_NEXT && !touched[$past(panel)])
    else $error("low sample did not record no touch");

  touch_start_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    state == RTS_IDLE_CONV && adc_done && req_sent && high_half
    |=> state == RTS_X_SET ##1 state == RTS_X_CONV)
    else $error("high sample did not start read");

  x_drive_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    state == RTS_X_CONV |-> drive[4*panel +: 4] == `RTS_PAT_X)
    else $error("x phase drive wrong");

  y_drive_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    state == RTS_Y_CONV |-> drive[4*panel +: 4] == `RTS_PAT_Y)
    else $error("y phase drive wrong");

  y_store_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    x_read_s ##[1:1000] y_read_s |=> pos[$past(panel)].y == $past(adc_data))
    else $error("y not stored");

  rotate_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    state == RTS_NEXT |=> panel == ($past(panel) == 2'(PANELS-1) ?
                          2'h0 : $past(panel) + 2'h1))
    else $error("panel rotation wrong");

  settle_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    adc_start |-> drive_age >= 16'(SETTLE_CYC) && $stable(state))
    else $error("request before settling");

  one_request_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    adc_start |=> !adc_start)
    else $error("request longer than one cycle");

  drive_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    req_sent |-> $stable(drive))
    else $error("drive moved during conversion");

  pos_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !(state == RTS_Y_CONV && adc_done && req_sent) |=> $stable(pos))
    else $error("position changed without a y read");

endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the touch scanner
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rts_pkg::*;
  localparam int S = 3;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] drive, adc_data, last_drv;
  logic adc_start, adc_done;
  logic [2:0] touched, pos_valid, press = 3'h0;
  logic [3:0] dly = 4'h1;
  rts_pos_type [2:0] pos;
  int bad_count = 0;
  int n_tests = 0;
  int stab, nf, k;
  always #10 ref_clk = ~ref_clk;
  rts_scan #(.SETTLE_CYC(S)) dut (.ref_clk(ref_clk), .rst(rst),
    .drive(drive), .adc_start(adc_start), .adc_done(adc_done),
    .adc_data(adc_data), .pos(pos), .touched(touched),
    .pos_valid(pos_valid));
  rts_panel_model model (.ref_clk(ref_clk), .rst(rst), .drive(drive),
    .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data),
    .press(press), .dly(dly));
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_valid(input logic [2:0] m);
    int i;
    for (i = 0; i < 3000 && (pos_valid & m) !== m; i++) @(posedge ref_clk);
    if (i == 3000) begin
      bad_count++;
      report_and_stop;
    end
  endtask
  // settle time and single active panel, seen at every request
  always @(posedge ref_clk) begin
    nf = 0;
    for (k = 0; k < 3; k++) if (drive[4*k +: 4] !== 4'hF) nf++;
    if (!rst && adc_start === 1'b1) begin
      chk(72'(stab >= S - 1), 72'h1);
      chk(72'(nf <= 1), 72'h1);
    end
    stab <= (rst || drive !== last_drv) ? 0 : stab + 1;
    last_drv <= drive;
  end
  task automatic t_reset;
    chk(72'({drive, adc_start, touched, pos_valid}), 72'h7FF80);
    chk(pos, 72'h0);
  endtask
  task automatic t_idle;
    repeat (300) @(posedge ref_clk);
    chk(72'({touched, pos_valid}), 72'h0);
  endtask
  task automatic t_one;
    @(posedge ref_clk) press <= 3'h2;
    wait_valid(3'h2);
    chk(72'({touched[1], pos_valid, pos[1]}), 72'hAA01501);
  endtask
  task automatic t_all;
    @(posedge ref_clk) dly <= 4'h9;
    press <= 3'h7;
    wait_valid(3'h7);
    repeat (400) @(posedge ref_clk);
    chk(72'(touched), 72'h7);
    chk(pos, 72'hA02502A01501A00500);
  endtask
  task automatic t_release;
    @(posedge ref_clk) press <= 3'h0;
    repeat (400) @(posedge ref_clk);
    chk(72'({touched, pos_valid}), 72'h07);
    chk(pos, 72'hA02502A01501A00500);
  endtask
  task automatic t_rerst;
    @(posedge ref_clk) rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(72'({drive, adc_start, touched, pos_valid}), 72'h7FF80);
    chk(pos, 72'h0);
    rst <= 1'b0;
    press <= 3'h1;
    wait_valid(3'h1);
    chk(72'({touched, pos_valid}), 72'h09);
    chk(pos, 72'hA00500);
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    t_reset;
    rst <= 1'b0;
    t_idle;
    t_one;
    t_all;
    t_release;
    t_rerst;
    report_and_stop;
  end
endmodule
`default_nettype wire
